/* File: hdl/apjb_ctrl.v */
// Aux pin routing, jack detect auto-mute and bias control registers on AHB-Lite
`timescale 1ns/1ps
`include "apjb_map.vh"
module apjb_ctrl #(
  parameter NUM_GAIN = 6
) (
  input  wire                sys_clk,
  input  wire                rst,
  input  wire                hsel,
  input  wire [31:0]         haddr,
  input  wire [1:0]          htrans,
  input  wire                hwrite,
  input  wire [2:0]          hsize,
  input  wire [31:0]         hwdata,
  input  wire                hready,
  output reg  [31:0]         hrdata,
  output wire                hreadyout,
  output wire                hresp,
  input  wire [4:0]          portData,
  input  wire                adcData,
  input  wire                auxPin1In,
  output wire                auxPin1Out,
  output wire                auxPin1Oe,
  input  wire                auxPin2In,
  output wire                auxPin2Out,
  output wire                auxPin2Oe,
  output reg  [NUM_GAIN-1:0] gainMute,
  output reg                 outputMuteAll,
  output reg  [5:0]          outputMute,
  output reg                 outputBiasSource,
  output reg                 referenceRampSpeed,
  output reg                 fastBiasEnable,
  output reg                 referenceBufferEnable,
  output reg                 referenceSoftRampEnable,
  output reg                 masterBiasEnable,
  output reg                 adcReferenceEnable,
  output reg  [1:0]          referenceResistorSelect,
  output reg                 jackDetected
);
  reg  [15:0] jackMuteReg;
  reg  [15:0] pinAppReg;
  reg  [15:0] biasReg;
  reg  [15:0] aux1RouteReg;
  reg  [15:0] aux2RouteReg;
  reg  [2:0]  aux1Applied;
  reg  [2:0]  aux2Applied;
  reg         wrPending;
  reg  [7:0]  wrIndex;
  reg  [31:0] next_hrdata;
  wire        sync1;
  wire        sync2;
  wire        jackRaw;
  wire        aux1Use;
  wire        aux2Use;
  wire        pin1Level;
  wire        pin2Level;
  wire        accept;
  wire [7:0]  aIndex;
  wire        wordXfer;
  wire        readReq;
  wire        wrJackMute;
  wire        wrPinApp;
  wire        wrBias;
  wire        wrAux1Route;
  wire        wrAux2Route;
  wire [15:0] jackMuteView;
  wire [15:0] pinAppView;
  wire [15:0] biasView;
  wire [15:0] aux1RouteView;
  wire [15:0] aux2RouteView;
  wire [7:0]  statusWord;
  wire        jackSelected;
  wire        jackLevel;
  wire [NUM_GAIN-1:0] muteRequest;
  genvar      g;

  // Single-cycle slave: never stalls, always OKAY; unmapped indices vanish on write and read zero
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  // Only whole-word transfers are taken; narrower ones are answered but change nothing
  assign wordXfer  = (hsize == 3'h2);
  assign accept    = hsel & hready & htrans[1] & wordXfer;
  assign readReq   = accept & ~hwrite;
  assign aIndex    = haddr[9:2];

  // Address phase capture; the write target is held one cycle so the data phase can land it
  // Reads need no capture here because their data is loaded at the address phase itself
  always @(posedge sys_clk) begin
    if (rst) begin
      wrPending <= 1'b0;
      wrIndex   <= 8'h00;
    end else begin
      wrPending <= accept & hwrite;
      wrIndex   <= aIndex;
    end
  end

  // Register writes during the data phase; only the low 16 bits are stored
  // Unused bits of the route registers are kept and read back as written
  always @(posedge sys_clk) begin
    if (rst) begin
      jackMuteReg  <= `APJB_RST_JACK_MUTE;
      pinAppReg    <= `APJB_RST_PIN_APP;
      biasReg      <= `APJB_RST_BIAS;          // Soft ramp set, resistor off
      aux1RouteReg <= `APJB_RST_ROUTE;
      aux2RouteReg <= `APJB_RST_ROUTE;
    end else if (wrPending) begin
      case (wrIndex)
        `APJB_IDX_JACK_MUTE:  jackMuteReg  <= hwdata[15:0];
        `APJB_IDX_PIN_APP:    pinAppReg    <= hwdata[15:0];
        `APJB_IDX_BIAS:       biasReg      <= hwdata[15:0];
        `APJB_IDX_AUX1_ROUTE: aux1RouteReg <= hwdata[15:0];
        `APJB_IDX_AUX2_ROUTE: aux2RouteReg <= hwdata[15:0];
        default: ;
      endcase
    end
  end

  // Deferred routing: stored always, applied only when the apply bit is written as 1
  // Only the applied select drives a pin, so a half-written setup never glitches it
  always @(posedge sys_clk) begin
    if (rst) begin
      aux1Applied <= 3'h0;
      aux2Applied <= 3'h0;
    end else if (wrPending) begin
      if (wrIndex == `APJB_IDX_AUX1_ROUTE && hwdata[`APJB_ROUTE_APPLY_BIT]) begin
        aux1Applied <= hwdata[`APJB_ROUTE_SEL_LSB+2:`APJB_ROUTE_SEL_LSB];
      end
      if (wrIndex == `APJB_IDX_AUX2_ROUTE && hwdata[`APJB_ROUTE_APPLY_BIT]) begin
        aux2Applied <= hwdata[`APJB_ROUTE_SEL_LSB+2:`APJB_ROUTE_SEL_LSB];
      end
    end
  end

  // Write strobes for the register whose data phase is under way
  assign wrJackMute  = wrPending & (wrIndex == `APJB_IDX_JACK_MUTE);
  assign wrPinApp    = wrPending & (wrIndex == `APJB_IDX_PIN_APP);
  assign wrBias      = wrPending & (wrIndex == `APJB_IDX_BIAS);
  assign wrAux1Route = wrPending & (wrIndex == `APJB_IDX_AUX1_ROUTE);
  assign wrAux2Route = wrPending & (wrIndex == `APJB_IDX_AUX2_ROUTE);

  // A read whose address phase meets the data phase of a write to the same register
  // sees the new word, so a pipelined write then read never returns stale contents
  assign jackMuteView  = wrJackMute  ? hwdata[15:0] : jackMuteReg;
  assign pinAppView    = wrPinApp    ? hwdata[15:0] : pinAppReg;
  assign biasView      = wrBias      ? hwdata[15:0] : biasReg;
  assign aux1RouteView = wrAux1Route ? hwdata[15:0] : aux1RouteReg;
  assign aux2RouteView = wrAux2Route ? hwdata[15:0] : aux2RouteReg;

  // Status shows the applied selects and the detect as they stand at the address phase
  assign statusWord = {1'b0, aux2Applied, aux1Applied, jackDetected};

  // Read mux on the address-phase index; unmapped indices read zero
  always @* begin
    next_hrdata = 32'h00000000;
    case (aIndex)
      `APJB_IDX_JACK_MUTE:  next_hrdata = {16'h0000, jackMuteView};
      `APJB_IDX_PIN_APP:    next_hrdata = {16'h0000, pinAppView};
      `APJB_IDX_BIAS:       next_hrdata = {16'h0000, biasView};
      `APJB_IDX_AUX1_ROUTE: next_hrdata = {16'h0000, aux1RouteView};
      `APJB_IDX_AUX2_ROUTE: next_hrdata = {16'h0000, aux2RouteView};
      `APJB_IDX_STATUS:     next_hrdata = {24'h000000, statusWord};
      default:              next_hrdata = 32'h00000000;
    endcase
  end

  // Read data is loaded at the address phase so that it stands through the data phase,
  // where the master samples it; it then holds until the next read
  always @(posedge sys_clk) begin
    if (rst) begin
      hrdata <= 32'h00000000;
    end else if (readReq) begin
      hrdata <= next_hrdata;
    end
  end

  assign aux1Use = pinAppReg[`APJB_APP_PIN1_BIT];
  assign aux2Use = pinAppReg[`APJB_APP_PIN2_BIT];

  // A pin given to jack detect is never driven, whatever select is applied to it
  // Pin one routing; input code also used when the pin serves jack detect
  apjb_pin_route #(
    .INPUT_CODE (`APJB_SRC_AUX1_INPUT),
    .OTHER_CODE (`APJB_SRC_AUX1_FROM2)
  ) uRoute1 (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .sourceSel (aux1Applied),
    .muxUse    (~aux1Use),
    .portData  (portData),
    .otherPin  (pin2Level),
    .adcData   (adcData),
    .pinOut    (auxPin1Out),
    .pinOe     (auxPin1Oe)
  );

  // Pin two routing
  apjb_pin_route #(
    .INPUT_CODE (`APJB_SRC_AUX2_INPUT),
    .OTHER_CODE (`APJB_SRC_AUX2_FROM1)
  ) uRoute2 (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .sourceSel (aux2Applied),
    .muxUse    (~aux2Use),
    .portData  (portData),
    .otherPin  (pin1Level),
    .adcData   (adcData),
    .pinOut    (auxPin2Out),
    .pinOe     (auxPin2Oe)
  );

  // Both pins are synchronised all the time, so changing a pin's use never exposes a raw level
  // Pin levels are synchronised before any logic sees them
  apjb_sync uSync1 (
    .sys_clk (sys_clk),
    .rst     (rst),
    .asyncIn (auxPin1In),
    .syncOut (sync1)
  );

  apjb_sync uSync2 (
    .sys_clk (sys_clk),
    .rst     (rst),
    .asyncIn (auxPin2In),
    .syncOut (sync2)
  );

  // Pin-to-pin forwarding passes through the synchroniser, costing two cycles of latency
  assign pin1Level = sync1;
  assign pin2Level = sync2;
  // Pin one wins if both are set as jack inputs
  assign jackRaw      = aux1Use ? sync1 : sync2;
  // With no pin given to jack detect the switch is ignored, whatever its level
  assign jackSelected = aux1Use | aux2Use;
  // Polarity bit clear: a low level means plugged
  assign jackLevel    = pinAppReg[`APJB_APP_POL_BIT] ? jackRaw : ~jackRaw;

  // One mute request per gain stage, bit 0 being gain stage one left
  generate
    for (g = 0; g < NUM_GAIN; g = g + 1) begin : gMute
      assign muteRequest[g] = jackDetected & jackMuteReg[`APJB_JMUTE_LSB+g];
    end
  endgenerate

  // Jack detection and automatic gain muting; the mute follows the detect by one cycle
  always @(posedge sys_clk) begin
    if (rst) begin
      jackDetected <= 1'b0;
      gainMute     <= {NUM_GAIN{1'b0}};
    end else begin
      jackDetected <= jackSelected & jackLevel;
      gainMute     <= muteRequest;
    end
  end

  // Bias and output mute controls to the analogue side. The host power sequences are
  // not policed here: every write reaches the analogue controls one cycle later, so a
  // host that skips the reference charge wait gets the pop it asked for
  always @(posedge sys_clk) begin
    if (rst) begin
      outputMuteAll           <= 1'b0;
      outputMute              <= 6'h00;
      outputBiasSource        <= 1'b0;
      referenceRampSpeed      <= 1'b0;
      fastBiasEnable          <= 1'b0;
      referenceBufferEnable   <= 1'b0;
      referenceSoftRampEnable <= 1'b1;
      masterBiasEnable        <= 1'b0;
      adcReferenceEnable      <= 1'b0;
      referenceResistorSelect <= 2'h0;
    end else begin
      outputMuteAll           <= jackMuteReg[0];
      outputMute              <= jackMuteReg[6:1];
      outputBiasSource        <= biasReg[`APJB_BIAS_OBS_BIT];
      referenceRampSpeed      <= biasReg[`APJB_BIAS_RAMP_BIT];
      fastBiasEnable          <= biasReg[`APJB_BIAS_FAST_BIT];
      referenceBufferEnable   <= biasReg[`APJB_BIAS_BUF_BIT];
      referenceSoftRampEnable <= biasReg[`APJB_BIAS_SOFT_BIT];
      masterBiasEnable        <= biasReg[`APJB_BIAS_MASTER_BIT];
      adcReferenceEnable      <= biasReg[`APJB_BIAS_MASTER_BIT];
      referenceResistorSelect <= biasReg[`APJB_BIAS_RES_LSB+1:`APJB_BIAS_RES_LSB];
    end
  end
endmodule // apjb_ctrl

/* File: hdl/apjb_map.vh */
// Register offsets, field positions and reset values for the aux pin, jack and bias control block
`ifndef APJB_MAP_VH
`define APJB_MAP_VH
// Register indices as printed; byte address is four times the index
`define APJB_IDX_JACK_MUTE      8'h1A
`define APJB_IDX_PIN_APP        8'h1B
`define APJB_IDX_BIAS           8'h23
`define APJB_IDX_AUX1_ROUTE     8'h2D
`define APJB_IDX_AUX2_ROUTE     8'h2E
`define APJB_IDX_STATUS         8'h30
// Reset values
`define APJB_RST_JACK_MUTE      16'h007E
`define APJB_RST_PIN_APP        16'h0048
`define APJB_RST_BIAS           16'h0010
`define APJB_RST_ROUTE          16'h0000
// Route register fields
`define APJB_ROUTE_SEL_LSB      1
`define APJB_ROUTE_APPLY_BIT    10
// Pin application register fields
`define APJB_APP_PIN1_BIT       0
`define APJB_APP_PIN2_BIT       1
`define APJB_APP_POL_BIT        2
// Jack mute register fields
`define APJB_JMUTE_LSB          7
`define APJB_JMUTE_WIDTH        6
// Bias register fields
`define APJB_BIAS_OBS_BIT       0
`define APJB_BIAS_RAMP_BIT      1
`define APJB_BIAS_FAST_BIT      2
`define APJB_BIAS_BUF_BIT       3
`define APJB_BIAS_SOFT_BIT      4
`define APJB_BIAS_MASTER_BIT    5
`define APJB_BIAS_RES_LSB       6
// Source select codes
`define APJB_SRC_AUX1_INPUT     3'h5
`define APJB_SRC_AUX1_FROM2     3'h6
`define APJB_SRC_AUX2_FROM1     3'h5
`define APJB_SRC_AUX2_INPUT     3'h6
`define APJB_SRC_ADC            3'h7
`endif

/* File: hdl/apjb_pin_route.v */
// Output mux for one auxiliary pin driven from its applied source select
`timescale 1ns/1ps
module apjb_pin_route #(
  parameter [2:0] INPUT_CODE = 3'h5,
  parameter [2:0] OTHER_CODE = 3'h6
) (
  input  wire       sys_clk,
  input  wire       rst,
  input  wire [2:0] sourceSel,
  input  wire       muxUse,
  input  wire [4:0] portData,
  input  wire       otherPin,
  input  wire       adcData,
  output reg        pinOut,
  output reg        pinOe
);
  reg next_pinOut;
  reg next_pinOe;

  // Source decode; pin is an input when chosen so or when used for jack detect
  always @* begin
    next_pinOut = 1'b0;
    next_pinOe  = muxUse;
    case (sourceSel)
      3'h0, 3'h1, 3'h2, 3'h3, 3'h4: next_pinOut = portData[sourceSel];
      INPUT_CODE: next_pinOe = 1'b0;
      OTHER_CODE: next_pinOut = otherPin;
      3'h7: next_pinOut = adcData;
      default: next_pinOut = 1'b0;
    endcase
  end

  // Registered pin drive
  always @(posedge sys_clk) begin
    if (rst) begin
      pinOut <= 1'b0;
      pinOe  <= 1'b0;
    end else begin
      pinOut <= next_pinOut;
      pinOe  <= next_pinOe;
    end
  end
endmodule // apjb_pin_route

/* File: hdl/apjb_sync.v */
// Two-flop synchroniser for a single level from outside the clock domain
`timescale 1ns/1ps
module apjb_sync (
  input  wire sys_clk,
  input  wire rst,
  input  wire asyncIn,
  output reg  syncOut
);
  reg stage1;

  // First stage is read only by the second
  always @(posedge sys_clk) begin
    if (rst) begin
      stage1  <= 1'b0;
      syncOut <= 1'b0;
    end else begin
      stage1  <= asyncIn;
      syncOut <= stage1;
    end
  end
endmodule // apjb_sync

/* File: verif/apjb_ctrl_chk.sv */
// Concurrent checks on the ports of the aux pin, jack and bias control block
`timescale 1ns/1ps
module apjb_ctrl_chk #(
  parameter NUM_GAIN = 6
) (
  input wire                sys_clk,
  input wire                rst,
  input wire                hsel,
  input wire [1:0]          htrans,
  input wire                hwrite,
  input wire                hready,
  input wire [31:0]         hrdata,
  input wire                hreadyout,
  input wire                hresp,
  input wire                auxPin1Oe,
  input wire                auxPin2Oe,
  input wire [NUM_GAIN-1:0] gainMute,
  input wire                jackDetected,
  input wire                outputBiasSource,
  input wire                referenceRampSpeed,
  input wire                fastBiasEnable,
  input wire                referenceBufferEnable,
  input wire                referenceSoftRampEnable,
  input wire                masterBiasEnable,
  input wire                adcReferenceEnable,
  input wire [1:0]          referenceResistorSelect
);
  reg dataWr;
  default clocking cbk @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Marks a write data phase; bias control outputs may only move just after one
  always @(posedge sys_clk) begin
    dataWr <= !rst && hsel && hready && htrans[1] && hwrite;
  end
  ready_ok_a: assert property (hreadyout && !hresp)
    else $error("bus answer is not ready with OKAY");
  adc_ref_a: assert property (adcReferenceEnable == masterBiasEnable)
    else $error("ADC reference enable differs from master bias");
  jack_mute_a: assert property (!$past(jackDetected) |-> gainMute == 0)
    else $error("gain stage muted with no jack present");
  mute_lag_a: assert property ($changed(gainMute) |->
    $past(jackDetected) != $past(jackDetected, 2) || $past(dataWr) || $past(dataWr, 2))
    else $error("gain mute moved without jack change or write");
  bias_write_a: assert property ($changed({outputBiasSource, referenceRampSpeed, fastBiasEnable,
    referenceBufferEnable, referenceSoftRampEnable, masterBiasEnable, referenceResistorSelect})
    |-> $past(dataWr) || $past(dataWr, 2))
    else $error("bias control moved without a write");
  reset_bias_a: assert property ($fell(rst) |->
    referenceSoftRampEnable && referenceResistorSelect == 2'h0 && !masterBiasEnable)
    else $error("bias controls not at reset values");
  pins_off_a: assert property ($fell(rst) |-> !auxPin1Oe && !auxPin2Oe)
    else $error("aux pin driven at reset release");
  read_upper_a: assert property ($past(hsel && hready && htrans[1] && !hwrite) |-> hrdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  cover property ($rose(jackDetected));
  cover property (gainMute != 0);
  cover property ($past(dataWr) && referenceResistorSelect == 2'h2);
endmodule // apjb_ctrl_chk
bind apjb_ctrl apjb_ctrl_chk #(.NUM_GAIN(NUM_GAIN)) u_apjb_ctrl_chk (.*);

/* File: verif/apjb_jack_sw.sv */
// Headphone jack switch on a pulled-up aux pin, resolving the pad wire
`timescale 1ns/1ps
module apjb_jack_sw (
  input  wire plugged,
  input  wire padOe,
  input  wire padOut,
  output wire pinLevel
);
  // Pad driver wins; otherwise a plug grounds the pulled-up line, so detect is active low
  assign pinLevel = padOe ? padOut : !plugged;
endmodule // apjb_jack_sw

/* File: verif/test_aux_pin_mux_jack_bias_ctrl.sv */
// Self-checking bench for the aux pin, jack and bias control block
`timescale 1ns/1ps
module test_aux_pin_mux_jack_bias_ctrl;
  logic        sys_clk, rst, hsel, hwrite, adcData, jackPlug1, jackPlug2;
  logic [31:0] haddr, hwdata, rdData;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [4:0]  portData;
  int          mismatches = 0;
  int          n_tests = 0;
  wire  [31:0] hrdata;
  wire  [5:0]  gainMute, outputMute;
  wire  [1:0]  referenceResistorSelect;
  wire         hready, hreadyout, hresp, auxPin1In, auxPin1Out, auxPin1Oe, auxPin2In, auxPin2Out, auxPin2Oe;
  wire         outputMuteAll, jackDetected, outputBiasSource, referenceRampSpeed, fastBiasEnable;
  wire         referenceBufferEnable, referenceSoftRampEnable, masterBiasEnable, adcReferenceEnable;
  // Rows: register index, write value, expected read back
  logic [39:0] rows [9] = '{
    40'h2300150015,
    40'h2300950095,
    40'h2300BD00BD,
    40'h23007C007C,
    40'h23006E006E,
    40'h23002F002F,
    40'h23000A000A,
    40'h3FFFFF0000,
    40'h1A14811481};
  logic [23:0] rstRows [4] = '{24'h1A007E, 24'h1B0048, 24'h230010, 24'h2E0000};
  // The one slave's ready is the bus ready
  assign hready = hreadyout;
  apjb_ctrl u_apjb_ctrl (.*);
  apjb_jack_sw u_apjb_jack_sw1 (.plugged(jackPlug1), .padOe(auxPin1Oe), .padOut(auxPin1Out), .pinLevel(auxPin1In));
  apjb_jack_sw u_apjb_jack_sw2 (.plugged(jackPlug2), .padOe(auxPin2Oe), .padOut(auxPin2Out), .pinLevel(auxPin2In));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Bounded wait for ready; a hang counts as a mismatch
  task automatic waitRdy();
    int k;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (hready !== 1'b1 && k < 50);
    if (hready !== 1'b1) begin
      mismatches++;
      finish_test();
    end
  endtask
  // One single word transfer; entered just after a rising edge
  task automatic ahb(input logic wr, input logic [7:0] idx, input logic [15:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {22'h0, idx, 2'h0};
    waitRdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {16'h0, wd};
    waitRdy();
    rdData = hrdata;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    portData = 5'h00;
    adcData = 1'b0;
    jackPlug1 = 1'b0;
    jackPlug2 = 1'b0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      ahb(1'b1, rows[i][39:32], rows[i][31:16]);
      ahb(1'b0, rows[i][39:32], 16'h0000);
      chk(rdData, {16'h0, rows[i][15:0]});
      if (rows[i][39:32] == 8'h23) begin
        chk({24'h0, referenceResistorSelect, masterBiasEnable, referenceSoftRampEnable, referenceBufferEnable,
             fastBiasEnable, referenceRampSpeed, outputBiasSource}, {24'h0, rows[i][23:16]});
      end
      chk({31'h0, adcReferenceEnable}, {31'h0, rows[i][39:32] == 8'h23 && rows[i][21]});
    end
    chk({25'h0, outputMuteAll, outputMute}, 32'h00000040);
    // Every pin two source code; each driving code seen at both levels, the input code seen undriven
    ahb(1'b1, 8'h2D, 16'h040A);
    for (int c = 0; c < 8; c++) begin
      ahb(1'b1, 8'h2E, {6'h01, 6'h00, c[2:0], 1'b0});
      for (int v = 0; v < 2; v++) begin
        portData  <= v[0] ? (5'h01 << c) : ~(5'h01 << c);
        adcData   <= (c == 7) ? v[0] : !v[0];
        jackPlug1 <= (c == 5) ? !v[0] : v[0];
        cyc(5);
        chk({31'h0, auxPin2Oe}, {31'h0, c != 6});
        if (c != 6) chk({31'h0, auxPin2Out}, {31'h0, v[0]});
      end
    end
    // Stored but not applied until the apply bit is written as one
    adcData  <= 1'b1;
    portData <= 5'h00;
    ahb(1'b1, 8'h2E, 16'h0000);
    cyc(5);
    chk({31'h0, auxPin2Out}, 32'h1);
    ahb(1'b1, 8'h2E, 16'h0400);
    cyc(5);
    chk({31'h0, auxPin2Out}, 32'h0);
    ahb(1'b1, 8'h2D, 16'h000E);
    cyc(5);
    chk({31'h0, auxPin1Oe}, 32'h0);
    ahb(1'b1, 8'h2D, 16'h040E);
    cyc(5);
    chk({30'h0, auxPin1Oe, auxPin1Out}, 32'h3);
    // Pin one forwarding pin two, which drives data port one high, then the status word
    portData <= 5'h01;
    ahb(1'b1, 8'h2D, 16'h040C);
    cyc(6);
    chk({30'h0, auxPin1Oe, auxPin1Out}, 32'h3);
    ahb(1'b0, 8'h30, 16'h0000);
    chk(rdData, 32'h0000000C);
    portData <= 5'h00;
    ahb(1'b1, 8'h2D, 16'h040A);
    // Jack on pin one, active low, then inverted, then on pin two
    jackPlug1 <= 1'b0;
    ahb(1'b1, 8'h1B, 16'h0049);
    cyc(5);
    chk({31'h0, jackDetected}, 32'h0);
    jackPlug1 <= 1'b1;
    cyc(1);
    chk({31'h0, jackDetected}, 32'h0);
    cyc(4);
    chk({25'h0, jackDetected, gainMute}, {25'h0, 1'b1, 6'h29});
    ahb(1'b1, 8'h1B, 16'h004D);
    cyc(5);
    chk({25'h0, jackDetected, gainMute}, 32'h0);
    jackPlug2 <= 1'b1;
    ahb(1'b1, 8'h1B, 16'h004A);
    cyc(5);
    chk({24'h0, auxPin2Oe, jackDetected, gainMute}, {24'h0, 2'b01, 6'h29});
    // Second reset in mid-run, then reset values
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
    cyc(2);
    chk({16'h0, outputMute, gainMute, referenceResistorSelect, referenceSoftRampEnable, masterBiasEnable},
        {16'h0, 6'h3F, 6'h00, 2'h0, 1'b1, 1'b0});
    foreach (rstRows[i]) begin
      ahb(1'b0, rstRows[i][23:16], 16'h0000);
      chk(rdData, {16'h0, rstRows[i][15:0]});
    end
    finish_test();
  end
endmodule // test_aux_pin_mux_jack_bias_ctrl
